// File: logic/skip_pkg.sv
// shared constants and types for the conditional forward skip sequencer
package skip_pkg;

  // list geometry: entries walked per scan, and index widths
  localparam int LIST_DEPTH = 64;
  localparam int IDX_W = 6;
  localparam int LEN_W = 7;

  // skip instances: 32 jumps and 32 targets, instance n held as n-1
  localparam int SKIP_COUNT = 32;
  localparam int NUM_W = 5;

  // reset values
  localparam logic [LEN_W-1:0] LEN_RESET = 7'h00;
  localparam logic [SKIP_COUNT-1:0] FAULT_RESET = 32'h0000_0000;
  localparam logic [15:0] EXEC_COUNT_RESET = 16'h0000;

  // kind of block held in one list entry
  typedef enum logic [1:0] {
    BLK_EMPTY = 2'b00,
    BLK_FUNCTION = 2'b01,
    BLK_COND_SKIP = 2'b10,
    BLK_SKIP_TARGET = 2'b11
  } block_kind_t;

  // one entry of the user-configured block list
  typedef struct packed {
    block_kind_t kind;
    logic [NUM_W-1:0] number;
  } list_entry_t;

  localparam list_entry_t ENTRY_RESET = '{kind: BLK_EMPTY, number: 5'h00};

  // request to the outside to process one ordinary function block
  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] index;
  } exec_req_t;

  localparam exec_req_t EXEC_RESET = '{valid: 1'b0, index: 6'h00};

  // scan sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FINISH = 2'b10
  } scan_state_t;

endpackage : skip_pkg

// File: logic/block_list_store.sv
// flip-flop storage of the block list, one write port, whole list visible
`timescale 1ns/1ns
module block_list_store (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [skip_pkg::IDX_W-1:0] i_index,
  input wire skip_pkg::list_entry_t i_entry,
  output skip_pkg::list_entry_t [skip_pkg::LIST_DEPTH-1:0] o_list
);

  // one entry written per cycle; all entries empty after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < skip_pkg::LIST_DEPTH; k++) begin
        o_list[k] <= skip_pkg::ENTRY_RESET;
      end
    end else if (i_we) begin
      o_list[i_index] <= i_entry;
    end
  end

endmodule : block_list_store

// File: logic/skip_target_finder.sv
// combinational search for the target block that matches a jump number
`timescale 1ns/1ns
module skip_target_finder (
  input skip_pkg::list_entry_t [skip_pkg::LIST_DEPTH-1:0] i_list,
  input wire logic [skip_pkg::NUM_W-1:0] i_number,
  input wire logic [skip_pkg::LEN_W-1:0] i_from,
  input wire logic [skip_pkg::LEN_W-1:0] i_limit,
  output logic o_fwd_found,
  output logic [skip_pkg::LEN_W-1:0] o_fwd_pos
);

  localparam int LEN_W = skip_pkg::LEN_W;

  // walk downward so the nearest target after the jump wins;
  // entries at or past the list length do not count as present
  always_comb begin
    o_fwd_found = 1'b0;
    o_fwd_pos = skip_pkg::LEN_RESET;
    for (int k = skip_pkg::LIST_DEPTH - 1; k >= 0; k--) begin
      if (i_list[k].kind == skip_pkg::BLK_SKIP_TARGET && i_list[k].number == i_number
          && LEN_W'(k) > i_from && LEN_W'(k) < i_limit) begin
        o_fwd_found = 1'b1;
        o_fwd_pos = LEN_W'(k);
      end
    end
  end

endmodule : skip_target_finder

// File: logic/conditional_forward_skip.sv
// scan sequencer that walks the block list with conditional forward skips
`timescale 1ns/1ns
module conditional_forward_skip (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scan_start,
  input wire logic [skip_pkg::LEN_W-1:0] i_list_length,
  input wire logic i_cfg_we,
  input wire logic [skip_pkg::IDX_W-1:0] i_cfg_index,
  input wire skip_pkg::list_entry_t i_cfg_entry,
  input wire logic [skip_pkg::SKIP_COUNT-1:0] i_skip_enable_coil,
  output skip_pkg::exec_req_t o_exec,
  output logic o_scan_busy,
  output logic o_scan_done,
  output logic [skip_pkg::SKIP_COUNT-1:0] o_skip_fault_contact,
  output logic [15:0] o_exec_count
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  skip_pkg::scan_state_t state;
  skip_pkg::scan_state_t next_state;
  logic [skip_pkg::LEN_W-1:0] pos;
  logic [skip_pkg::LEN_W-1:0] next_pos;
  logic [skip_pkg::LEN_W-1:0] len;
  logic [skip_pkg::LEN_W-1:0] next_len;
  logic [skip_pkg::SKIP_COUNT-1:0] next_fault;
  skip_pkg::exec_req_t next_exec;
  logic [15:0] next_exec_count;

  //////////////////////////////////////////////////////////////////////////////
  // list storage

  skip_pkg::list_entry_t [skip_pkg::LIST_DEPTH-1:0] list;
  wire logic cfg_write;

  // rewriting the list mid-scan would tear the walk, so writes are dropped unless idle
  assign cfg_write = i_cfg_we && state == skip_pkg::ST_IDLE;

  block_list_store u_store (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(cfg_write),
    .i_index(i_cfg_index),
    .i_entry(i_cfg_entry),
    .o_list(list)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode of the entry under the walk position

  wire logic at_end;
  wire logic running;
  wire skip_pkg::list_entry_t cur;
  wire logic is_function;
  wire logic is_skip;
  wire logic is_target;
  wire logic skip_enabled;

  // the walk position may reach the length, one past the last entry
  assign at_end = pos >= len;
  assign running = state == skip_pkg::ST_RUN;
  assign cur = list[pos[skip_pkg::IDX_W-1:0]];
  assign is_function = running && !at_end && cur.kind == skip_pkg::BLK_FUNCTION;
  assign is_skip = running && !at_end && cur.kind == skip_pkg::BLK_COND_SKIP;
  // marker only
  // a target entry raises no processing request and just advances the walk
  assign is_target = running && !at_end && cur.kind == skip_pkg::BLK_SKIP_TARGET;
  // 32 skip instances
  // the 5-bit number selects one of 32 enable coils
  assign skip_enabled = i_skip_enable_coil[cur.number];

  //////////////////////////////////////////////////////////////////////////////
  // target lookup

  wire logic fwd_found;
  wire logic [skip_pkg::LEN_W-1:0] fwd_pos;

  // numbered targets
  // only a target with the same number and after the skip is accepted
  skip_target_finder u_finder (
    .i_list(list),
    .i_number(cur.number),
    .i_from(pos),
    .i_limit(len),
    .o_fwd_found(fwd_found),
    .o_fwd_pos(fwd_pos)
  );

  //////////////////////////////////////////////////////////////////////////////
  // skip decision

  wire logic skip_take;
  wire logic skip_bad;
  wire logic [skip_pkg::LEN_W-1:0] after_target;
  wire logic [skip_pkg::LEN_W-1:0] after_current;

  // forward only
  // a valid forward target lets the walk resume right after it
  assign skip_take = is_skip && skip_enabled && fwd_found;
  // bad target
  // backward or missing target: the finder reports nothing forward
  assign skip_bad = is_skip && skip_enabled && !fwd_found;
  assign after_target = skip_pkg::LEN_W'(fwd_pos + 7'h01);
  assign after_current = skip_pkg::LEN_W'(pos + 7'h01);

  //////////////////////////////////////////////////////////////////////////////
  // next walk position

  // fall through
  // a disabled skip, a target or a function block all step to the next entry
  assign next_pos = (state == skip_pkg::ST_IDLE) ? skip_pkg::LEN_RESET
                  : !running || at_end ? pos
                  : skip_take ? after_target
                  : skip_bad ? len
                  : after_current;

  //////////////////////////////////////////////////////////////////////////////
  // scan state machine

  wire logic [skip_pkg::LEN_W-1:0] len_capped;

  // a length past the list depth would wrap the entry index and run blocks twice
  assign len_capped = (i_list_length > skip_pkg::LEN_W'(skip_pkg::LIST_DEPTH)) ? skip_pkg::LEN_W'(skip_pkg::LIST_DEPTH)
                    : i_list_length;

  // scan restart
  // every scan begins at entry zero with the length captured at its start
  always_comb begin
    next_state = state;
    next_len = len;
    case (state)
      skip_pkg::ST_IDLE: begin
        if (i_scan_start) begin
          next_state = skip_pkg::ST_RUN;
          next_len = len_capped;
        end
      end
      skip_pkg::ST_RUN: begin
        if (at_end) begin
          next_state = skip_pkg::ST_FINISH;
        end
      end
      skip_pkg::ST_FINISH: begin
        next_state = skip_pkg::ST_IDLE;
      end
      default: begin
        next_state = skip_pkg::ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // fault contacts

  wire logic [skip_pkg::SKIP_COUNT-1:0] skip_onehot;

  assign skip_onehot = skip_pkg::SKIP_COUNT'(1) << cur.number;

  // per scan
  // each evaluated skip rewrites its own contact; a disabled skip opens it
  assign next_fault = !is_skip ? o_skip_fault_contact
                    : skip_bad ? (o_skip_fault_contact | skip_onehot)
                    : (o_skip_fault_contact & ~skip_onehot);

  //////////////////////////////////////////////////////////////////////////////
  // processing requests

  // only function blocks
  // a skipped block never reaches the request port
  assign next_exec = '{valid: is_function, index: pos[skip_pkg::IDX_W-1:0]};
  assign next_exec_count = (state == skip_pkg::ST_IDLE && i_scan_start) ? skip_pkg::EXEC_COUNT_RESET
                         : is_function ? 16'(o_exec_count + 16'h0001)
                         : o_exec_count;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  // sequencer state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= skip_pkg::ST_IDLE;
      pos <= skip_pkg::LEN_RESET;
      len <= skip_pkg::LEN_RESET;
    end else begin
      state <= next_state;
      pos <= next_pos;
      len <= next_len;
    end
  end

  // outputs, all registered
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_exec <= skip_pkg::EXEC_RESET;
      o_scan_busy <= 1'b0;
      o_scan_done <= 1'b0;
      o_skip_fault_contact <= skip_pkg::FAULT_RESET;
      o_exec_count <= skip_pkg::EXEC_COUNT_RESET;
    end else begin
      o_exec <= next_exec;
      o_scan_busy <= next_state != skip_pkg::ST_IDLE;
      o_scan_done <= state == skip_pkg::ST_FINISH; // one-cycle end-of-scan
      o_skip_fault_contact <= next_fault;
      o_exec_count <= next_exec_count;
    end
  end

endmodule : conditional_forward_skip

// File: logic/skip_target_finder_note.sv
// intentionally empty: no extra module
`timescale 1ns/1ns

// File: testbench/conditional_forward_skip_assertions.sv
// port-level assertions for the skip sequencer
`timescale 1ns/1ns
module conditional_forward_skip_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scan_start,
  input wire logic [skip_pkg::LEN_W-1:0] i_list_length,
  input wire skip_pkg::exec_req_t o_exec,
  input wire logic o_scan_busy,
  input wire logic o_scan_done,
  input wire logic [skip_pkg::SKIP_COUNT-1:0] o_skip_fault_contact,
  input wire logic [15:0] o_exec_count
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////
  // scan start and scan end steps
  sequence s_idle_start; !o_scan_busy && i_scan_start; endsequence
  sequence s_end; o_scan_done && !o_scan_busy; endsequence
  property p_start_busy; s_idle_start |=> o_scan_busy; endproperty
  property p_fall_done; $fell(o_scan_busy) |-> s_end; endproperty
  property p_done_idle; o_scan_done |-> !o_scan_busy; endproperty
  property p_done_once; o_scan_done |=> !o_scan_done; endproperty
  // longest list is 64 entries plus the finish cycles
  property p_scan_bounded; $rose(o_scan_busy) |-> ##[1:70] s_end; endproperty
  property p_exec_in_scan; o_exec.valid |-> o_scan_busy && (o_exec.index < i_list_length); endproperty
  // outputs only move while a scan walks the list
  property p_fault_idle; !o_scan_busy |=> $stable(o_skip_fault_contact); endproperty
  property p_count_idle; !o_scan_busy && !i_scan_start |=> $stable(o_exec_count); endproperty
  // last processed index of the current scan, forgotten between scans
  logic seen_exec;
  logic [skip_pkg::IDX_W-1:0] last_index;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_exec <= 1'b0;
      last_index <= 6'h00;
    end else if (!o_scan_busy) begin
      seen_exec <= 1'b0;
    end else if (o_exec.valid) begin
      seen_exec <= 1'b1;
      last_index <= o_exec.index;
    end
  end
  property p_exec_forward; o_exec.valid && seen_exec |-> o_exec.index > last_index; endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy missing after start");
  a_fall_done: assert property (p_fall_done) else $error("busy fell without done");
  a_done_idle: assert property (p_done_idle) else $error("done while busy");
  a_done_once: assert property (p_done_once) else $error("done longer than one cycle");
  a_scan_bounded: assert property (p_scan_bounded) else $error("scan never ended");
  a_exec_in_scan: assert property (p_exec_in_scan) else $error("exec outside the list");
  a_fault_idle: assert property (p_fault_idle) else $error("fault moved while idle");
  a_count_idle: assert property (p_count_idle) else $error("count moved while idle");
  a_exec_forward: assert property (p_exec_forward) else $error("walk went backward");
endmodule : conditional_forward_skip_assertions

bind conditional_forward_skip conditional_forward_skip_assertions u_conditional_forward_skip_assertions (
  .i_clk, .i_rst_n, .i_scan_start, .i_list_length, .o_exec, .o_scan_busy, .o_scan_done,
  .o_skip_fault_contact, .o_exec_count);

// File: testbench/conditional_forward_skip_tb.sv
// self-checking bench for the skip sequencer
`timescale 1ns/1ns
module conditional_forward_skip_tb;
  logic i_clk, i_rst_n, i_scan_start, i_cfg_we;
  logic [skip_pkg::LEN_W-1:0] i_list_length;
  logic [skip_pkg::IDX_W-1:0] i_cfg_index;
  skip_pkg::list_entry_t i_cfg_entry;
  logic [31:0] i_skip_enable_coil;
  skip_pkg::exec_req_t o_exec;
  logic o_scan_busy, o_scan_done;
  logic [31:0] o_skip_fault_contact;
  logic [15:0] o_exec_count;
  int fails = 0;
  int check_count = 0;
  localparam skip_pkg::list_entry_t fn = '{kind: skip_pkg::BLK_FUNCTION, number: 5'h00};

  conditional_forward_skip u_conditional_forward_skip (.i_clk, .i_rst_n, .i_scan_start, .i_list_length,
    .i_cfg_we, .i_cfg_index, .i_cfg_entry, .i_skip_enable_coil, .o_exec, .o_scan_busy, .o_scan_done,
    .o_skip_fault_contact, .o_exec_count);

  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////
  function automatic skip_pkg::list_entry_t sk(input logic [4:0] n);
    return '{kind: skip_pkg::BLK_COND_SKIP, number: n};
  endfunction : sk

  function automatic skip_pkg::list_entry_t tg(input logic [4:0] n);
    return '{kind: skip_pkg::BLK_SKIP_TARGET, number: n};
  endfunction : tg

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // write entries back to back, one per cycle
  task automatic load(input skip_pkg::list_entry_t q[$]);
    foreach (q[i]) begin
      i_cfg_we = 1'b1;
      i_cfg_index = 6'(i);
      i_cfg_entry = q[i];
      @(negedge i_clk);
    end
    i_cfg_we = 1'b0;
  endtask : load

  // run one scan, gather executed indices as a mask; order is implied by forward-only walk
  task automatic scan(input logic [6:0] len, input logic [31:0] coil, input logic [63:0] mask_exp,
      input logic [15:0] cnt_exp, input logic [31:0] fault_exp);
    logic [63:0] mask;
    int n;
    mask = '0;
    n = 0;
    i_list_length = len;
    i_skip_enable_coil = coil;
    i_scan_start = 1'b1;
    @(negedge i_clk);
    i_scan_start = 1'b0;
    while (o_scan_done !== 1'b1 && n < 200) begin
      if (o_exec.valid === 1'b1) mask[o_exec.index] = 1'b1;
      @(negedge i_clk);
      n++;
    end
    if (n >= 200) begin
      fails++;
      finish_test();
    end
    check(mask, mask_exp, "executed blocks");
    check(64'(o_exec_count), 64'(cnt_exp), "exec count");
    check(64'(o_skip_fault_contact), 64'(fault_exp), "fault contacts");
    @(negedge i_clk);
  endtask : scan

  ////////////////////////////////////////////////////////////
  // highest instance with a decoy target of another number between
  task automatic t_forward;
    load('{fn, sk(5'h1f), tg(5'h00), fn, tg(5'h1f), fn});
    scan(7'd6, 32'h8000_0000, 64'h21, 16'h0002, 32'h0);
    $display("test forward done");
  endtask : t_forward

  task automatic t_no_skip_repeat;
    scan(7'd6, 32'h0, 64'h29, 16'h0003, 32'h0);
    scan(7'd6, 32'h8000_0000, 64'h21, 16'h0002, 32'h0);
    scan(7'd6, 32'h8000_0000, 64'h21, 16'h0002, 32'h0);
    $display("test no skip and repeat done");
  endtask : t_no_skip_repeat

  // target placed before its skip
  task automatic t_backward;
    load('{fn, tg(5'h02), fn, sk(5'h02), fn});
    scan(7'd5, 32'h4, 64'h05, 16'h0002, 32'h4);
    $display("test backward done");
  endtask : t_backward

  // skip whose target is missing; a disabled skip reopens its contact
  task automatic t_missing;
    load('{fn, sk(5'h03), fn});
    scan(7'd3, 32'h8, 64'h01, 16'h0001, 32'hc);
    scan(7'd3, 32'h0, 64'h05, 16'h0002, 32'h4);
    scan(7'd0, 32'h0, 64'h00, 16'h0000, 32'h4);
    $display("test missing target done");
  endtask : t_missing

  initial begin
    i_rst_n = 1'b0;
    i_scan_start = 1'b0;
    i_cfg_we = 1'b0;
    i_list_length = '0;
    i_cfg_index = '0;
    i_cfg_entry = fn;
    i_skip_enable_coil = '0;
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    t_forward();
    t_no_skip_repeat();
    t_backward();
    t_missing();
    finish_test();
  end
endmodule : conditional_forward_skip_tb
